// ===== rtl/stc_params.svh
// Register offsets, field positions, reset values and timing counts of the
// sixteen-bit timer control block. Assumes a 32-bit classic Wishbone bus.
//
// Notes on behaviour
// - Prescale codes 11, 10, 01 divide 8, 4, 2.
// - Control bit 3 enables low-power oscillator.
// - Bit 2 set: external input counts unsynchronized.
// - Internal source ignores the synchronization bit.
// - Bit 1 selects external rising edge or Fosc/4.
// - Bit 0 runs counter; cleared holds its value.
// - Control bits 7 and 6 read zero.
// - Power-on reset clears control; other resets keep.
// - Counter seen as high and low byte registers.
// - Overflow flag at bit 0 of flags register.
// - Overflow enable at bit 0 of enable register.
// - Rollover from FFFFh sets sticky overflow flag.
// - Counter byte write loads counter, clears prescaler.
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define STC_OFS_CTRL    8'h00
`define STC_OFS_FLAGS   8'h04
`define STC_OFS_IRQ_EN  8'h08
`define STC_OFS_CNT_HI  8'h0C
`define STC_OFS_CNT_LO  8'h10
`define STC_OFS_INTCTL  8'h14

// ----------------------------------------------------------------------
// Field positions and implemented-bit masks
// ----------------------------------------------------------------------
`define STC_BIT_OVF     0
`define STC_CTRL_MASK   8'h3F
`define STC_PIR_MASK    8'h47

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define STC_RST_CTRL    8'h00
`define STC_RST_FLAGS   8'h00
`define STC_RST_IRQ_EN  8'h00
`define STC_RST_INTCTL  8'h00
`define STC_RST_CNT     16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define STC_CLK_HZ      20_000_000
`define STC_INSTR_HZ    5_000_000
`define STC_INSTR_DIV   (`STC_CLK_HZ / `STC_INSTR_HZ)

`endif

// ===== rtl/stc_pkg.sv
// Types shared by the sixteen-bit timer control block.
// Assumes stc_params.svh is on the include path.
package stc_pkg;

    // ------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] input_prescale_select;
        logic       low_power_osc_enable;
        logic       external_sync_disable;
        logic       clock_source_select;
        logic       counter_run;
    } stc_ctrl_type;

    // ------------------------------------------------------------------
    // Bus answer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } stc_bus_type;

    // ------------------------------------------------------------------
    // Whole state of the main module
    // ------------------------------------------------------------------
    typedef struct packed {
        stc_bus_type  bus;
        logic         ack;
        logic [7:0]   rdat;
        stc_ctrl_type ctrl;
        logic [7:0]   flags;
        logic [7:0]   irq_en;
        logic [7:0]   intctl;
        logic [15:0]  cnt;
        logic [1:0]   quarter;
        logic [2:0]   sync;
        logic [1:0]   raw;
    } stc_state_type;

    // ------------------------------------------------------------------
    // Prescaler state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cnt;
    } stc_presc_type;

endpackage

// ===== rtl/stc_prescaler.sv
// Input prescaler of the timer: passes one of every 1, 2, 4 or 8 ticks.
// Assumes tick_i is a one-cycle pulse on clk_i.
`timescale 1ns/10ps
`include "stc_params.svh"
module stc_prescaler
    import stc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       clear_i,
    input  wire logic [1:0] select_i,
    // Ticks
    input  wire logic       tick_i,
    output logic            out_o
);

    stc_presc_type s_reg;
    stc_presc_type s_next;
    logic [2:0]    mask;

    function automatic logic [2:0] div_mask(input logic [1:0] sel);
        div_mask = 3'h7 >> (2'd3 - sel);
    endfunction

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    always_comb begin
        mask   = div_mask(select_i);
        s_next = s_reg;
        out_o  = tick_i & ~clear_i & ((s_reg.cnt & mask) == mask);
        if (clear_i) begin
            s_next.cnt = 3'h0;
        end else if (tick_i) begin
            s_next.cnt = s_reg.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    undivided_pass_a: assert property (tick_i && !clear_i && select_i == 2'b00 |-> out_o)
        else $error("undivided tick not passed");
    div_eight_a: assert property (out_o && select_i == 2'b11 |-> s_reg.cnt == 3'h7)
        else $error("divide by eight fired early");
    div_two_a: assert property (out_o && select_i == 2'b01 |-> s_reg.cnt[0])
        else $error("divide by two fired early");
    div_four_a: assert property (out_o && select_i == 2'b10 |-> s_reg.cnt[1:0] == 2'b11)
        else $error("divide by four fired early");
    presc_clear_a: assert property (clear_i |=> s_reg.cnt == 3'h0)
        else $error("prescale count not cleared");

endmodule

// ===== rtl/stc_timer.sv
// Sixteen-bit timer control block with a classic Wishbone register slave.
// Assumes clk_i is the 20 MHz oscillator and all inputs but external_count_input_i are synchronous.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "stc_params.svh"
module stc_timer
    import stc_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and resets
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              warm_rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Pins
    input  wire logic              external_count_input_i,
    output logic                   low_power_osc_enable_o,
    output logic      [15:0]       counter_value_o,
    output logic                   overflow_flag_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    generate
        if (ADDR_W < 8) begin : g_bad_width
            $error("ADDR_W must be at least 8");
        end
    endgenerate

    stc_state_type s_reg;
    stc_state_type s_next;
    logic [7:0]    addr;
    logic          req;
    logic          wr;
    logic          cnt_wr;
    logic          ext_edge;
    logic          src_pulse;
    logic          presc_tick;
    logic          presc_clear;
    logic          inc;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Request decode and count sources
    // ------------------------------------------------------------------
    always_comb begin
        addr   = adr_i[7:0];
        req    = cyc_i & stb_i & (s_reg.bus == BUS_IDLE);
        // A warm reset keeps control and counter, so writes during it are dropped.
        wr     = req & we_i & sel_i[0] & ~warm_rst_i;
        cnt_wr = wr & (hit(addr, `STC_OFS_CNT_HI) | hit(addr, `STC_OFS_CNT_LO));
        if (s_reg.ctrl.external_sync_disable) begin
            ext_edge = s_reg.raw[0] & ~s_reg.raw[1];
        end else begin
            ext_edge = s_reg.sync[1] & ~s_reg.sync[2];
        end
        if (s_reg.ctrl.clock_source_select) begin
            src_pulse = ext_edge;
        end else begin
            // The sync bit plays no part on the internal path.
            src_pulse = (s_reg.quarter == 2'(`STC_INSTR_DIV - 1));
        end
        presc_tick  = s_reg.ctrl.counter_run & src_pulse & ~warm_rst_i;
        presc_clear = cnt_wr | warm_rst_i;
    end

    stc_prescaler u_presc (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (presc_clear),
        .select_i (s_reg.ctrl.input_prescale_select),
        .tick_i   (presc_tick),
        .out_o    (inc)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next         = s_reg;
        s_next.ack     = 1'b0;
        s_next.quarter = s_reg.quarter + 2'h1;
        // The first sync stage feeds only the second; sync edges come from later stages, raw edges from both raw stages.
        s_next.sync    = {s_reg.sync[1:0], external_count_input_i};
        s_next.raw     = {s_reg.raw[0], external_count_input_i};

        case (s_reg.bus)
            BUS_IDLE: begin
                if (req) begin
                    s_next.bus = BUS_ANSWER;
                    s_next.ack = 1'b1;
                    if (hit(addr, `STC_OFS_CTRL)) begin
                        s_next.rdat = s_reg.ctrl;
                    end else if (hit(addr, `STC_OFS_FLAGS)) begin
                        s_next.rdat = s_reg.flags;
                    end else if (hit(addr, `STC_OFS_IRQ_EN)) begin
                        s_next.rdat = s_reg.irq_en;
                    end else if (hit(addr, `STC_OFS_CNT_HI)) begin
                        s_next.rdat = s_reg.cnt[15:8];
                    end else if (hit(addr, `STC_OFS_CNT_LO)) begin
                        s_next.rdat = s_reg.cnt[7:0];
                    end else if (hit(addr, `STC_OFS_INTCTL)) begin
                        s_next.rdat = s_reg.intctl;
                    end else begin
                        s_next.rdat = 8'h00;
                    end
                end
            end
            BUS_ANSWER: begin
                s_next.bus = BUS_IDLE;
            end
            default: begin
                s_next.bus = BUS_IDLE;
            end
        endcase

        if (wr) begin
            if (hit(addr, `STC_OFS_CTRL)) begin
                s_next.ctrl = dat_i[7:0] & `STC_CTRL_MASK;
            end else if (hit(addr, `STC_OFS_FLAGS)) begin
                s_next.flags = dat_i[7:0] & `STC_PIR_MASK;
            end else if (hit(addr, `STC_OFS_IRQ_EN)) begin
                s_next.irq_en = dat_i[7:0] & `STC_PIR_MASK;
            end else if (hit(addr, `STC_OFS_INTCTL)) begin
                s_next.intctl = dat_i[7:0];
            end
        end

        // A byte write beats a coincident increment of the counter.
        if (cnt_wr) begin
            if (hit(addr, `STC_OFS_CNT_HI)) begin
                s_next.cnt[15:8] = dat_i[7:0];
            end else begin
                s_next.cnt[7:0] = dat_i[7:0];
            end
        end else if (inc) begin
            s_next.cnt = s_reg.cnt + 16'h0001;
            if (s_reg.cnt == 16'hFFFF) begin
                // Setting wins over a software clear in the same cycle.
                s_next.flags[`STC_BIT_OVF] = 1'b1;
            end
        end

        // Warm resets clear flags and enables but keep control and counter.
        if (warm_rst_i) begin
            s_next.flags  = `STC_RST_FLAGS;
            s_next.irq_en = `STC_RST_IRQ_EN;
            s_next.intctl = `STC_RST_INTCTL;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg        <= '0;
            s_reg.bus    <= BUS_IDLE;
            s_reg.ctrl   <= `STC_RST_CTRL;
            s_reg.flags  <= `STC_RST_FLAGS;
            s_reg.irq_en <= `STC_RST_IRQ_EN;
            s_reg.intctl <= `STC_RST_INTCTL;
            s_reg.cnt    <= `STC_RST_CNT;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign dat_o                  = {24'h00_0000, s_reg.rdat};
    assign ack_o                  = s_reg.ack;
    assign low_power_osc_enable_o = s_reg.ctrl.low_power_osc_enable;
    assign counter_value_o        = s_reg.cnt;
    assign overflow_flag_o        = s_reg.flags[`STC_BIT_OVF];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_roll;
        inc && !cnt_wr && s_reg.cnt == 16'hFFFF;
    endsequence

    sequence s_wrapped;
        s_reg.cnt == 16'h0000 && s_reg.flags[0] ##1 s_reg.flags[0] || warm_rst_i;
    endsequence

    ctrl_top_zero_a: assert property (s_reg.ctrl[7:6] == 2'b00)
        else $error("control bits 7 and 6 not zero");
    por_clear_a: assert property ($fell(rst_i) |-> s_reg.ctrl == 8'h00)
        else $error("control not cleared after power-on reset");
    warm_keep_a: assert property (warm_rst_i |=> $stable(s_reg.ctrl) && $stable(s_reg.cnt))
        else $error("warm reset changed control or counter");
    stop_hold_a: assert property (!s_reg.ctrl.counter_run && !cnt_wr |=> $stable(s_reg.cnt))
        else $error("stopped counter moved");
    roll_flag_a: assert property (s_roll |=> s_wrapped)
        else $error("rollover did not set flag");
    lo_write_a: assert property (cnt_wr && hit(addr, `STC_OFS_CNT_LO)
                                 |=> s_reg.cnt[7:0] == $past(dat_i[7:0]))
        else $error("low byte write not loaded");
    int_source_a: assert property (inc && !s_reg.ctrl.clock_source_select
                                   |-> s_reg.quarter == 2'h3)
        else $error("internal count off instruction clock");
    ext_source_a: assert property (inc && s_reg.ctrl.clock_source_select
                                   |-> ext_edge && $past(external_count_input_i))
        else $error("external count without rising edge");
    flag_read_a: assert property (req && !we_i && hit(addr, `STC_OFS_FLAGS)
                                  |=> ack_o && dat_o[0] == $past(s_reg.flags[0]))
        else $error("flag read wrong");

    // ------------------------------------------------------------------
    // Bus answer and register write checks
    // ------------------------------------------------------------------
    // A taken request is answered on the next cycle, even in a warm reset.
    ack_answer_a: assert property (req
                                   |=> ack_o)
        else $error("request not acknowledged");

    // A second acknowledge would let a slow master take one access twice.
    ack_pulse_a: assert property (ack_o
                                  |=> !ack_o)
        else $error("acknowledge stood two cycles");

    ctrl_write_a: assert property (wr && hit(addr, `STC_OFS_CTRL)
                                   |=> s_reg.ctrl == ($past(dat_i[7:0]) & `STC_CTRL_MASK))
        else $error("control write not stored");

    osc_follow_a: assert property (wr && hit(addr, `STC_OFS_CTRL)
                                   |=> low_power_osc_enable_o == $past(dat_i[3]))
        else $error("oscillator enable not following");

    hi_write_a: assert property (cnt_wr && hit(addr, `STC_OFS_CNT_HI)
                                 |=> s_reg.cnt[15:8] == $past(dat_i[7:0]))
        else $error("high byte write not loaded");

    // ------------------------------------------------------------------
    // Counting checks
    // ------------------------------------------------------------------
    int_tick_a: assert property (s_reg.ctrl.counter_run && !s_reg.ctrl.clock_source_select
                                 && s_reg.quarter == 2'h3 && !warm_rst_i |-> presc_tick)
        else $error("internal tick missed");

    count_step_a: assert property (inc && !cnt_wr
                                   |=> s_reg.cnt == $past(s_reg.cnt) + 16'h0001)
        else $error("counter did not step by one");

    overflow_pin_a: assert property (s_roll
                                     |=> overflow_flag_o)
        else $error("overflow output not raised");

    // Only a software write or a warm reset may drop the overflow flag.
    flag_sticky_a: assert property (s_reg.flags[0] && !wr && !warm_rst_i
                                    |=> s_reg.flags[0])
        else $error("overflow flag dropped by itself");

endmodule

// ===== test/stc_count_source.sv
// External count source that drives the timer's count pin in bursts.
// Assumes go_i is a one-cycle request on clk_i while busy_o is low.
`timescale 1ns/10ps
module stc_count_source (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Request
    input  wire logic       go_i,
    input  wire logic [3:0] pulses_i,
    // Pin and status
    output logic            pin_o,
    output logic            busy_o
);
    logic [3:0] left_reg;
    logic [2:0] phase_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_reg  <= 4'h0;
            phase_reg <= 3'h0;
        end else if (go_i && !busy_o) begin
            left_reg  <= pulses_i;
            phase_reg <= 3'h0;
        end else if (left_reg != 4'h0) begin
            phase_reg <= phase_reg + 3'h1;
            if (phase_reg == 3'h7) begin
                left_reg <= left_reg - 4'h1;
            end
        end
    end

    // Four clocks low then four high, so each pulse has one rising edge and
    // the pin rests low between bursts as a stopped source would.
    assign busy_o = (left_reg != 4'h0);
    assign pin_o  = busy_o && phase_reg[2];
endmodule

// ===== test/tb_stc_timer.sv
// Self-checking testbench of the sixteen-bit timer control block.
// Assumes stc_pkg, stc_prescaler, stc_timer and stc_count_source are compiled.
`timescale 1ns/10ps
`include "stc_params.svh"
`define CHK(name, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", name, exp, got); end end
module tb_stc_timer
    import stc_pkg::*;
;
    logic        clk_i, rst_i, warm_rst_i, cyc_i, stb_i, we_i, ack_o, osc_o, ovf_o;
    logic        pin, go, busy;
    logic [3:0]  sel_i, pulses;
    logic [7:0]  adr_i, q;
    logic [31:0] dat_i, dat_o;
    logic [15:0] cnt_o, v;
    logic [7:0]  offs [6] = '{`STC_OFS_CTRL, `STC_OFS_FLAGS, `STC_OFS_IRQ_EN,
                               `STC_OFS_CNT_HI, `STC_OFS_CNT_LO, `STC_OFS_INTCTL};
    int          fail_count, tests_run, cycles, p;

    stc_timer stc_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .warm_rst_i(warm_rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .external_count_input_i(pin),
        .low_power_osc_enable_o(osc_o), .counter_value_o(cnt_o), .overflow_flag_o(ovf_o));
    stc_count_source stc_count_source_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .pulses_i(pulses), .pin_o(pin), .busy_o(busy));

    // ------------------------------------------------------------------
    // Bus, source and measurement tasks
    // ------------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h00_0000, d};
        sel_i <= 4'hF;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o[7:0];
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask

    task automatic ext(input logic [3:0] n);
        @(posedge clk_i);
        go <= 1'b1; pulses <= n;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        while (busy) @(posedge clk_i);
        repeat (6) @(posedge clk_i);
    endtask

    // Cycles between two counter changes; the first gap may be partial.
    task automatic period();
        v = cnt_o;
        @(posedge clk_i);
        while (cnt_o === v) @(posedge clk_i);
        v = cnt_o; p = 0;
        do begin @(posedge clk_i); p++; end while (cnt_o === v);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and tests
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        rst_i = 1'b1; warm_rst_i = 1'b0; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
        adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0000_0000; go = 1'b0; pulses = 4'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wb(0, offs[i], 8'h00); `CHK("reset value", 8'h00, q)
        end
        wb(1, `STC_OFS_CTRL, 8'hFF); wb(0, `STC_OFS_CTRL, 8'h00);
        `CHK("control", 8'h3F, q)
        `CHK("osc enable", 1'b1, osc_o)
        wb(1, `STC_OFS_CTRL, 8'h00); `CHK("osc enable", 1'b0, osc_o)
        wb(0, 8'h20, 8'h00); `CHK("unmapped", 8'h00, q)
        wb(1, `STC_OFS_IRQ_EN, 8'hFF); wb(0, `STC_OFS_IRQ_EN, 8'h00);
        `CHK("irq enable", 8'h47, q)
        // Sync bit set with internal source must not change the rate.
        for (int c = 0; c < 4; c++) begin
            wb(1, `STC_OFS_CTRL, {2'b00, c[1:0], 4'b0101}); period(); period();
            `CHK("period", 4 << c, p)
        end
        wb(1, `STC_OFS_CTRL, 8'h00); v = cnt_o; repeat (40) @(posedge clk_i);
        `CHK("held count", v, cnt_o)
        wb(1, `STC_OFS_FLAGS, 8'h00);
        wb(1, `STC_OFS_CNT_HI, 8'hFF); wb(1, `STC_OFS_CNT_LO, 8'hF0);
        wb(0, `STC_OFS_CNT_HI, 8'h00); `CHK("count high", 8'hFF, q)
        wb(0, `STC_OFS_CNT_LO, 8'h00); `CHK("count low", 8'hF0, q)
        wb(1, `STC_OFS_CTRL, 8'h01); repeat (100) @(posedge clk_i);
        wb(1, `STC_OFS_CTRL, 8'h00);
        `CHK("overflow pin", 1'b1, ovf_o)
        wb(0, `STC_OFS_FLAGS, 8'h00); `CHK("flags", 8'h01, q)
        wb(0, `STC_OFS_CNT_HI, 8'h00); `CHK("rolled high", 8'h00, q)
        wb(1, `STC_OFS_FLAGS, 8'h00); `CHK("cleared flag", 1'b0, ovf_o)
        for (int s = 0; s < 2; s++) begin
            wb(1, `STC_OFS_CNT_HI, 8'h00); wb(1, `STC_OFS_CNT_LO, 8'h00);
            wb(1, `STC_OFS_CTRL, {5'b00000, s[0], 2'b11}); ext(4'd3);
            wb(0, `STC_OFS_CNT_LO, 8'h00); `CHK("pin count", 8'h03, q)
        end
        // A partial prescale count must be lost on a counter write.
        wb(1, `STC_OFS_CTRL, 8'h33); ext(4'd5); wb(1, `STC_OFS_CNT_LO, 8'h10);
        ext(4'd7); wb(0, `STC_OFS_CNT_LO, 8'h00); `CHK("no step", 8'h10, q)
        ext(4'd1); wb(0, `STC_OFS_CNT_LO, 8'h00); `CHK("one step", 8'h11, q)
        wb(1, `STC_OFS_CTRL, 8'h32); wb(1, `STC_OFS_FLAGS, 8'h01);
        warm_rst_i <= 1'b1; repeat (3) @(posedge clk_i); warm_rst_i <= 1'b0;
        wb(0, `STC_OFS_CTRL, 8'h00); `CHK("kept control", 8'h32, q)
        wb(0, `STC_OFS_CNT_LO, 8'h00); `CHK("kept count", 8'h11, q)
        wb(0, `STC_OFS_FLAGS, 8'h00); `CHK("warm flags", 8'h00, q)
        // A second power-on reset in mid-run must clear control and counter.
        rst_i <= 1'b1; repeat (2) @(posedge clk_i); rst_i <= 1'b0;
        wb(0, `STC_OFS_CTRL, 8'h00); `CHK("por control", 8'h00, q)
        wb(0, `STC_OFS_CNT_LO, 8'h00); `CHK("por count", 8'h00, q)
        summarize();
    end
endmodule
